//--- sacc_pkg.sv
// Purpose: constants for the converter conversion control block
// Assumes: 25 MHz system clock, plain register port
// Notes:   register offsets are word indices on the register port
//
// Behaviour
// - converter runs only while conv_enable is one, else shutdown
// - positive selector: port inputs, temp sensor, supply; negative: ports, vref, ground
// - ground as negative input means single-ended, anything else differential
// - single-ended result is 10-bit unsigned
// - unsigned results have unused bits zero in both justifications
// - differential result is 10-bit two's complement
// - right-justified differential: upper high-byte bits repeat the sign
// - left-justified differential: unused low bits read zero
// - result sits in high and low bytes, justified by left_justify_sel
// - conversion clock is system clock divided by divider field plus one
// - start source chosen by start_mode_sel among six sources
// - timer 2/3: low byte overflow in 8-bit, high byte in 16-bit mode
// - conv_busy is one throughout a conversion, zero when done
// - falling edge of busy sets conv_done_flag and raises interrupt if enabled (a shutdown abort drops busy without setting the flag)
// - result bytes hold the data whenever conv_done_flag reads one
// - normal track mode tracks continuously except during conversion
// - low-power track mode tracks 3 conversion clocks after each start
// - low-power with pin source: track while pin low; rising edge starts 3 more track clocks, then convert
// - tracking may be disabled while the chip is in standby or sleep
// - write of one to busy starts only when start mode is 000b
// - start codes 001 and 010 select timer 0 and timer 2 overflow
package sacc_pkg;
    // register indices on the plain port
    localparam logic [2:0] SACC_REG_CTRL   = 3'h0;  // conv_control_reg
    localparam logic [2:0] SACC_REG_CFG    = 3'h1;  // conv_config_reg
    localparam logic [2:0] SACC_REG_POS    = 3'h2;  // pos_input_select
    localparam logic [2:0] SACC_REG_NEG    = 3'h3;  // neg_input_select
    localparam logic [2:0] SACC_REG_RES_HI = 3'h4;  // result_high_byte
    localparam logic [2:0] SACC_REG_RES_LO = 3'h5;  // result_low_byte
    localparam logic [2:0] SACC_REG_IEN    = 3'h6;  // interrupt enable and timer modes
    // control register fields
    localparam int SACC_CTRL_EN     = 7;
    localparam int SACC_CTRL_TM     = 6;
    localparam int SACC_CTRL_DONE   = 5;
    localparam int SACC_CTRL_BUSY   = 4;
    localparam int SACC_CTRL_WIN    = 3;
    localparam int SACC_CTRL_CM_LSB = 0;
    // config register fields
    localparam int SACC_CFG_SC_LSB  = 3;
    localparam int SACC_CFG_LJST    = 2;
    // extra register fields
    localparam int SACC_IEN_IRQ     = 0;
    localparam int SACC_IEN_T2_16   = 1;
    localparam int SACC_IEN_T3_16   = 2;
    // reset values
    localparam logic [7:0] SACC_CTRL_RST = 8'h00;
    localparam logic [7:0] SACC_CFG_RST  = 8'hf8;
    localparam logic [4:0] SACC_SEL_RST  = 5'h00;
    // input selector codes
    localparam logic [4:0] SACC_POS_TEMP = 5'h1e;
    localparam logic [4:0] SACC_POS_VDD  = 5'h1f;
    localparam logic [4:0] SACC_NEG_VREF = 5'h1e;
    localparam logic [4:0] SACC_NEG_GND  = 5'h1f;
    localparam logic [4:0] SACC_PORT_MAX = 5'h14;
    // start-of-conversion modes
    typedef enum logic [2:0] {
        SACC_CM_SW   = 3'h0,
        SACC_CM_T0   = 3'h1,
        SACC_CM_T2   = 3'h2,
        SACC_CM_T1   = 3'h3,
        SACC_CM_PIN  = 3'h4,
        SACC_CM_T3   = 3'h5,
        SACC_CM_RSV6 = 3'h6,
        SACC_CM_RSV7 = 3'h7
    } sacc_cm_t;
    // timing
    localparam int          SACC_TRACK_CLKS = 3;
    localparam logic [1:0]  SACC_TRACK_LAST = 2'(SACC_TRACK_CLKS - 1);
    localparam int          SACC_RES_BITS   = 10;
    localparam logic [3:0]  SACC_CONV_CLKS  = 4'hb;  // 10 bit steps plus one settle
    localparam int          SACC_MAX_KSPS   = 200;
endpackage : sacc_pkg

//--- sacc_ctrl.sv
// Purpose: conversion control for a 10-bit successive-approximation converter
// Assumes: analog core returns a comparator bit per conversion-clock step
// Notes:   triggers from timers arrive as same-clock one-cycle pulses
//
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module sacc_ctrl
    import sacc_pkg::*;
(
    // clock and reset
    input  wire logic       mclk_i,
    input  wire logic       rst_i,
    // register port
    input  wire logic [2:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    // start sources
    input  wire logic       t0_ovf_i,
    input  wire logic       t1_ovf_i,
    input  wire logic       t2_lo_ovf_i,
    input  wire logic       t2_hi_ovf_i,
    input  wire logic       t3_lo_ovf_i,
    input  wire logic       t3_hi_ovf_i,
    input  wire logic       ext_conv_start_pin_i,
    input  wire logic       chip_standby_i,
    // analog core
    input  wire logic       cmp_i,
    output logic            analog_on_o,
    output logic            track_o,
    output logic            single_ended_o,
    output logic      [4:0] pos_sel_o,
    output logic      [4:0] neg_sel_o,
    output logic      [9:0] dac_code_o,
    output logic            sar_clk_en_o,
    // status
    output logic            conv_busy_o,
    output logic            conv_done_o,
    output logic            irq_o
);
    typedef enum logic [1:0] {
        SACC_IDLE  = 2'b00,
        SACC_TRACK = 2'b01,
        SACC_CONV  = 2'b11
    } sacc_st_t;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] cfg;
        logic [4:0] pos;
        logic [4:0] neg;
        logic [2:0] ien;
        logic [7:0] res_hi;
        logic [7:0] res_lo;
        logic [7:0] rdata;
        logic [4:0] div;
        logic       sar_en;
        sacc_st_t   st;
        logic [1:0] trk;
        logic [3:0] step;
        logic [9:0] sar;
        logic       pin_s1;
        logic       pin_s2;
        logic       pin_s3;
    } sacc_state_t;

    sacc_state_t s_reg;
    sacc_state_t s_next;

    logic     en;
    logic     lp_track;
    logic     ljst;
    logic     diff;
    logic     pin_rise;
    logic     trig;
    logic     start;
    logic     busy;
    logic     fin;
    logic     done_set;
    logic     done_clr;
    logic [9:0] code;
    sacc_cm_t cm;

    // decoded control fields
    assign en       = s_reg.ctrl[SACC_CTRL_EN];
    assign lp_track = s_reg.ctrl[SACC_CTRL_TM];
    assign ljst     = s_reg.cfg[SACC_CFG_LJST];
    assign cm       = sacc_cm_t'(s_reg.ctrl[SACC_CTRL_CM_LSB +: 3]);
    assign diff     = (s_reg.neg != SACC_NEG_GND);
    assign pin_rise = s_reg.pin_s2 & ~s_reg.pin_s3;
    assign busy     = (s_reg.st != SACC_IDLE);

    // start source select
    always_comb begin
        trig = 1'b0;
        unique case (cm)
            SACC_CM_SW:  trig = wr_i && addr_i == SACC_REG_CTRL
                                && wdata_i[SACC_CTRL_BUSY];
            SACC_CM_T0:  trig = t0_ovf_i;
            SACC_CM_T2:  trig = s_reg.ien[SACC_IEN_T2_16] ? t2_hi_ovf_i
                                                          : t2_lo_ovf_i;
            SACC_CM_T1:  trig = t1_ovf_i;
            SACC_CM_PIN: trig = pin_rise;
            SACC_CM_T3:  trig = s_reg.ien[SACC_IEN_T3_16] ? t3_hi_ovf_i
                                                          : t3_lo_ovf_i;
            SACC_CM_RSV6,
            SACC_CM_RSV7: trig = 1'b0;
        endcase
    end
    // a trigger during a conversion is dropped, not queued
    assign start = en && trig && !busy;

    // last bit decided on a conversion-clock tick ends the conversion
    assign fin      = (s_reg.st == SACC_CONV) && s_reg.sar_en
                      && (s_reg.step == SACC_CONV_CLKS - 4'h1);
    assign done_set = fin;
    assign done_clr = wr_i && addr_i == SACC_REG_CTRL && !wdata_i[SACC_CTRL_DONE];

    // final code: differential flips msb back to two's complement
    always_comb begin
        code = s_reg.sar;
        if (!cmp_i) begin
            code = s_reg.sar & ~(10'h200 >> (s_reg.step - 4'h1)); // last trial is bit 0
        end
        if (diff) begin
            code = code ^ 10'h200;
        end
    end

    // next-state logic
    always_comb begin
        s_next        = s_reg;
        s_next.pin_s1 = ext_conv_start_pin_i;
        s_next.pin_s2 = s_reg.pin_s1;
        s_next.pin_s3 = s_reg.pin_s2;
        s_next.rdata  = 8'h00;

        // conversion clock divider, runs only when enabled
        s_next.sar_en = 1'b0;
        if (!en) begin
            s_next.div = 5'h00;
        end else if (s_reg.div == s_reg.cfg[SACC_CFG_SC_LSB +: 5]) begin
            s_next.div    = 5'h00;
            s_next.sar_en = 1'b1;
        end else begin
            s_next.div = s_reg.div + 5'h01;
        end

        // register writes
        if (wr_i) begin
            unique case (addr_i)
                SACC_REG_CTRL: begin
                    // busy is hardware-owned; done is clear-only
                    s_next.ctrl[7:6] = wdata_i[7:6];
                    s_next.ctrl[3:0] = wdata_i[3:0];
                end
                SACC_REG_CFG: s_next.cfg = {wdata_i[7:2], 2'b00};
                SACC_REG_POS: s_next.pos = wdata_i[4:0];
                SACC_REG_NEG: s_next.neg = wdata_i[4:0];
                SACC_REG_IEN: s_next.ien = wdata_i[2:0];
                default: ;
            endcase
        end
        // set wins over a clear in the same cycle
        if (done_clr) begin
            s_next.ctrl[SACC_CTRL_DONE] = 1'b0;
        end
        if (done_set) begin
            s_next.ctrl[SACC_CTRL_DONE] = 1'b1;
        end

        // conversion sequence
        unique case (s_reg.st)
            SACC_IDLE: begin
                if (start) begin
                    s_next.trk  = 2'h0;
                    s_next.step = 4'h0;
                    s_next.sar  = 10'h000;
                    s_next.st   = lp_track ? SACC_TRACK : SACC_CONV;
                end
            end
            SACC_TRACK: begin
                if (s_reg.sar_en) begin
                    if (s_reg.trk == SACC_TRACK_LAST) begin
                        s_next.st = SACC_CONV;
                    end else begin
                        s_next.trk = s_reg.trk + 2'h1;
                    end
                end
            end
            SACC_CONV: begin
                if (s_reg.sar_en) begin
                    if (fin) begin
                        s_next.st = SACC_IDLE;
                        // results written with the done flag, so they agree
                        if (ljst) begin
                            s_next.res_hi = code[9:2];
                            s_next.res_lo = {code[1:0], 6'h00};
                        end else begin
                            s_next.res_hi = {{6{diff & code[9]}}, code[9:8]};
                            s_next.res_lo = code[7:0];
                        end
                    end else begin
                        if (s_reg.step != 4'h0) begin
                            s_next.sar = cmp_i ? s_reg.sar
                                               : s_reg.sar & ~(10'h200 >> (s_reg.step - 4'h1));
                        end
                        s_next.sar  = s_next.sar | (10'h200 >> s_reg.step);
                        s_next.step = s_reg.step + 4'h1;
                    end
                end
            end
            default: s_next.st = SACC_IDLE;
        endcase
        // shutdown aborts any conversion in flight
        if (!en) begin
            s_next.st = SACC_IDLE;
        end

        // read data, one cycle after the strobe
        if (rd_i) begin
            unique case (addr_i)
                SACC_REG_CTRL: s_next.rdata = {s_reg.ctrl[7:5], busy, s_reg.ctrl[3:0]};
                SACC_REG_CFG: s_next.rdata = s_reg.cfg;
                SACC_REG_POS: s_next.rdata = {3'h0, s_reg.pos};
                SACC_REG_NEG: s_next.rdata = {3'h0, s_reg.neg};
                SACC_REG_RES_HI: s_next.rdata = s_reg.res_hi;
                SACC_REG_RES_LO: s_next.rdata = s_reg.res_lo;
                SACC_REG_IEN: s_next.rdata = {5'h00, s_reg.ien};
                default: s_next.rdata = 8'h00;
            endcase
        end
    end

    // state register
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            s_reg        <= '0;
            s_reg.ctrl   <= SACC_CTRL_RST;
            s_reg.cfg    <= SACC_CFG_RST;
            s_reg.pos    <= SACC_SEL_RST;
            s_reg.neg    <= SACC_SEL_RST;
            s_reg.st     <= SACC_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    // tracking: normal mode tracks unless converting, low-power in track phase or, with pin start, while pin low
    always_comb begin
        track_o = 1'b0;
        if (en && !chip_standby_i) begin
            if (!lp_track) begin
                track_o = (s_reg.st != SACC_CONV);
            end else if (cm == SACC_CM_PIN) begin
                track_o = !s_reg.pin_s2 || s_reg.st == SACC_TRACK;
            end else begin
                track_o = (s_reg.st == SACC_TRACK);
            end
        end
    end

    // outputs
    assign rdata_o        = s_reg.rdata;
    assign analog_on_o    = en;
    assign single_ended_o = !diff;
    assign pos_sel_o      = s_reg.pos;
    assign neg_sel_o      = s_reg.neg;
    assign dac_code_o     = s_reg.sar;
    assign sar_clk_en_o   = s_reg.sar_en;
    assign conv_busy_o    = busy;
    assign conv_done_o    = s_reg.ctrl[SACC_CTRL_DONE];
    assign irq_o          = s_reg.ctrl[SACC_CTRL_DONE] & s_reg.ien[SACC_IEN_IRQ];
endmodule : sacc_ctrl
`default_nettype wire

//--- sacc_ctrl_checker.sv
// Purpose: port-level checks for the conversion control block
// Assumes: one clock, synchronous active-high reset
// Notes:   bound onto every sacc_ctrl instance
`timescale 1ns/10ps
`default_nettype none
module sacc_ctrl_checker
    import sacc_pkg::*;
(
    // clock, reset and register port
    input wire logic       mclk_i,
    input wire logic       rst_i,
    input wire logic [2:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic       wr_i,
    input wire logic       rd_i,
    input wire logic [7:0] rdata_o,
    // converter outputs
    input wire logic       analog_on_o,
    input wire logic       track_o,
    input wire logic       single_ended_o,
    input wire logic [4:0] neg_sel_o,
    input wire logic       sar_clk_en_o,
    input wire logic       conv_busy_o,
    input wire logic       conv_done_o,
    input wire logic       irq_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    logic [4:0] cnt_reg;
    logic       clr_done;
    logic [2:0] cm_reg;
    // conversion-clock pulses seen within one busy period
    always_ff @(posedge mclk_i) begin
        if (rst_i || !conv_busy_o)
            cnt_reg <= 5'h00;
        else if (sar_clk_en_o)
            cnt_reg <= cnt_reg + 5'h01;
    end
    // mirror of the stored start mode; a software start obeys the stored field
    always_ff @(posedge mclk_i) begin
        if (rst_i)
            cm_reg <= 3'h0;
        else if (wr_i && addr_i == SACC_REG_CTRL)
            cm_reg <= wdata_i[SACC_CTRL_CM_LSB +: 3];
    end
    // only this write may drop the sticky done flag
    assign clr_done = wr_i && addr_i == SACC_REG_CTRL && !wdata_i[SACC_CTRL_DONE];
    off_no_track_a: assert property (!analog_on_o |-> !track_o)
        else $error("tracking while disabled");
    start_enabled_a: assert property ($rose(conv_busy_o) |-> analog_on_o)
        else $error("conversion started while disabled");
    mode_decode_a: assert property (single_ended_o == (neg_sel_o == SACC_NEG_GND))
        else $error("single-ended decode wrong");
    sw_start_a: assert property (wr_i && addr_i == SACC_REG_CTRL && analog_on_o
        && wdata_i[SACC_CTRL_BUSY] && cm_reg == 3'h0 && !conv_busy_o |=> conv_busy_o)
        else $error("software start ignored");
    conv_length_a: assert property ($fell(conv_busy_o) && analog_on_o
        |-> cnt_reg == 5'h0b || cnt_reg == 5'h0e)
        else $error("wrong conversion clock count");
    done_on_fall_a: assert property ($fell(conv_busy_o) && analog_on_o |-> conv_done_o)
        else $error("done not set at busy fall");
    done_sticky_a: assert property (conv_done_o && !clr_done |=> conv_done_o)
        else $error("done dropped without clear");
    irq_done_a: assert property (irq_o |-> conv_done_o)
        else $error("interrupt without done");
    rd_idle_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data outside read slot");
    status_rd_a: assert property (rd_i && addr_i == SACC_REG_CTRL |=>
        rdata_o[SACC_CTRL_BUSY] == $past(conv_busy_o)
        && rdata_o[SACC_CTRL_DONE] == $past(conv_done_o))
        else $error("status read mismatch");
    cover property ($fell(conv_busy_o) && conv_done_o);
    cover property ($rose(conv_busy_o) && track_o);
    cover property (irq_o);
endmodule : sacc_ctrl_checker
bind sacc_ctrl sacc_ctrl_checker i_sacc_ctrl_checker (.mclk_i(mclk_i), .rst_i(rst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .analog_on_o(analog_on_o), .track_o(track_o), .single_ended_o(single_ended_o),
    .neg_sel_o(neg_sel_o), .sar_clk_en_o(sar_clk_en_o), .conv_busy_o(conv_busy_o),
    .conv_done_o(conv_done_o), .irq_o(irq_o));
`default_nettype wire

//--- sacc_analog_model.sv
// Purpose: comparator stand-in for the converter's analog core
// Assumes: input level given as an offset-binary code
// Notes:   a shut-down core answers with a toggling, meaningless bit
`timescale 1ns/10ps
`default_nettype none
module sacc_analog_model
    import sacc_pkg::*;
(
    // clock and core controls
    input  wire logic       mclk_i,
    input  wire logic       analog_on_i,
    input  wire logic [9:0] dac_code_i,
    input  wire logic [9:0] level_i,
    // comparator answer
    output logic            cmp_o
);
    logic tog_reg = 1'b0;
    // toggle so a powered-down core never looks like a steady answer
    always_ff @(posedge mclk_i) begin
        tog_reg <= !tog_reg;
    end
    // keep the trial bit while the trial does not exceed the input
    assign cmp_o = analog_on_i ? (dac_code_i <= level_i) : tog_reg;
endmodule : sacc_analog_model
`default_nettype wire

//--- tb_sacc_ctrl.sv
// Purpose: self-checking bench for the conversion control block
// Assumes: analog core replaced by a comparator model
// Notes:   each scenario is one task that judges its own results
`timescale 1ns/10ps
`default_nettype none
module tb_sacc_ctrl
    import sacc_pkg::*;
;
    logic       mclk_i = 1'b0;
    logic       rst_i = 1'b1;
    logic [2:0] addr_i = 3'h0;
    logic [7:0] wdata_i = 8'h00;
    logic       wr_i = 1'b0;
    logic       rd_i = 1'b0;
    logic [6:0] src = 7'h00;
    logic       standby = 1'b0;
    logic [9:0] level = 10'h000;
    logic [7:0] rdata_o;
    logic [4:0] pos_sel_o, neg_sel_o;
    logic [9:0] dac_code_o;
    logic       cmp_i, analog_on_o, track_o, single_ended_o;
    logic       sar_clk_en_o, conv_busy_o, conv_done_o, irq_o;
    int         err_total = 0;
    int         checked = 0;
    always #20 mclk_i = !mclk_i;
    sacc_ctrl i_sacc_ctrl (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .t0_ovf_i(src[0]),
        .t1_ovf_i(src[1]), .t2_lo_ovf_i(src[2]), .t2_hi_ovf_i(src[3]), .t3_lo_ovf_i(src[4]),
        .t3_hi_ovf_i(src[5]), .ext_conv_start_pin_i(src[6]), .chip_standby_i(standby),
        .cmp_i(cmp_i), .analog_on_o(analog_on_o), .track_o(track_o),
        .single_ended_o(single_ended_o), .pos_sel_o(pos_sel_o), .neg_sel_o(neg_sel_o),
        .dac_code_o(dac_code_o), .sar_clk_en_o(sar_clk_en_o), .conv_busy_o(conv_busy_o),
        .conv_done_o(conv_done_o), .irq_o(irq_o));
    sacc_analog_model i_sacc_analog_model (.mclk_i(mclk_i), .analog_on_i(analog_on_o),
        .dac_code_i(dac_code_o), .level_i(level), .cmp_o(cmp_i));
    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", what, e, g);
            err_total++;
        end
    endtask : chk
    // one-cycle strobes; a gap cycle follows so no signal is set twice per step
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask : wr
    task automatic rdchk(input logic [2:0] a, input logic [7:0] e);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1;
        chk("rdata", e, rdata_o);
    endtask : rdchk
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask : tick
    task automatic pulse(input int i);
        @(posedge mclk_i);
        src <= 7'(1 << i);
        @(posedge mclk_i);
        src <= 7'h00;
    endtask : pulse
    // bounded wait; the watchdog covers a design that never finishes
    task automatic wait_done;
        for (int n = 0; n < 2000 && conv_done_o !== 1'b1; n++)
            tick(1);
    endtask : wait_done
    // times one full conversion-clock period, starting from a seen pulse
    task automatic sar_period(input logic [4:0] dv);
        int n;
        #1;
        for (n = 0; n < 99 && sar_clk_en_o !== 1'b1; n++)
            tick(1);
        n = 0;
        do begin
            tick(1);
            n++;
        end while (n < 99 && sar_clk_en_o !== 1'b1);
        chk("sar period", 16'(dv) + 16'h1, 16'(n));
    endtask : sar_period
    task automatic t_regs;
        for (int a = 0; a < 8; a++)
            rdchk(3'(a), a == 1 ? SACC_CFG_RST : 8'h00);
        wr(3'h7, 8'hff);
        rdchk(3'h7, 8'h00);
        wr(SACC_REG_POS, {3'h0, SACC_POS_TEMP});
        wr(SACC_REG_NEG, {3'h0, SACC_NEG_VREF});
        rdchk(SACC_REG_POS, {3'h0, SACC_POS_TEMP});
        chk("single", 0, single_ended_o);
        chk("pos sel", 16'(SACC_POS_TEMP), 16'(pos_sel_o));
        wr(SACC_REG_NEG, {3'h0, SACC_NEG_GND});
        tick(1);
        chk("single", 1, single_ended_o);
        chk("neg sel", 16'(SACC_NEG_GND), 16'(neg_sel_o));
    endtask : t_regs
    task automatic t_track;
        wr(SACC_REG_CTRL, 8'h80);
        tick(1);
        chk("track", 1, track_o);
        wr(SACC_REG_CFG, 8'h00);
        sar_period(5'h00);
        @(posedge mclk_i) standby <= 1'b1;
        tick(2);
        chk("track", 0, track_o);
        @(posedge mclk_i) standby <= 1'b0;
        wr(SACC_REG_CFG, 8'hf8);
        wr(SACC_REG_CTRL, 8'h90);
        wr(SACC_REG_CTRL, 8'h00);
        tick(2);
        chk("busy", 0, conv_busy_o);
        chk("done", 0, conv_done_o);
        chk("track", 0, track_o);
    endtask : t_track
    task automatic t_conv(input logic tm, lj, input logic [4:0] ng, dv, input logic [9:0] t);
        logic [9:0]  v;
        logic [15:0] w;
        v = ng == SACC_NEG_GND ? t : t ^ 10'h200;
        w = lj ? {v, 6'h00} : ng == SACC_NEG_GND ? {6'h00, v} : {{6{v[9]}}, v};
        @(posedge mclk_i) level <= t;
        wr(SACC_REG_CFG, {dv, lj, 2'b00});
        wr(SACC_REG_NEG, {3'h0, ng});
        wr(SACC_REG_IEN, 8'h01);
        wr(SACC_REG_CTRL, {1'b1, tm, 6'h00}); // start reads the stored enable and mode
        wr(SACC_REG_CTRL, {1'b1, tm, 6'h10});
        #1;
        chk("busy", 1, conv_busy_o);
        chk("track", tm, track_o);
        sar_period(dv);
        wait_done;
        chk("busy", 0, conv_busy_o);
        chk("irq", 1, irq_o);
        rdchk(SACC_REG_RES_HI, w[15:8]);
        rdchk(SACC_REG_RES_LO, w[7:0]);
        wr(SACC_REG_CTRL, {1'b1, tm, 6'h20});
        tick(1);
        chk("done", 1, conv_done_o);
        wr(SACC_REG_CTRL, {1'b1, tm, 6'h00});
        tick(1);
        chk("irq", 0, irq_o);
    endtask : t_conv
    // software start bit must be ignored outside mode 000, wrong sources too
    task automatic t_trig(input logic [2:0] cm, input logic [7:0] ie, input int ok, bad);
        wr(SACC_REG_IEN, ie);
        wr(SACC_REG_CTRL, {5'h10, cm}); // mode stored before the refused start bit
        wr(SACC_REG_CTRL, {5'h12, cm});
        pulse(bad);
        tick(6);
        chk("stray start", 0, conv_busy_o);
        pulse(ok);
        tick(5);
        chk("start", ok < 7, conv_busy_o);
        if (ok < 7)
            wait_done;
        chk("done", ok < 7, conv_done_o);
        wr(SACC_REG_CTRL, 8'h80);
    endtask : t_trig
    task automatic t_pin_lp;
        wr(SACC_REG_CTRL, 8'hc4);
        tick(4);
        chk("track", 1, track_o);
        @(posedge mclk_i) src[6] <= 1'b1;
        tick(6);
        chk("busy", 1, conv_busy_o);
        wait_done;
        chk("track", 0, track_o);
        @(posedge mclk_i) src[6] <= 1'b0;
        tick(4);
        chk("track", 1, track_o);
    endtask : t_pin_lp
    task automatic finish_test;
        if (err_total == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : finish_test
    // budget far above the few thousand cycles the scenarios need
    initial begin
        repeat (30000) @(posedge mclk_i);
        err_total++;
        finish_test;
    end
    initial begin
        repeat (12) @(posedge mclk_i);
        rst_i <= 1'b0;
        t_regs;
        t_track;
        for (int i = 0; i < 8; i++)
            t_conv(i[2], i[0], i[1] ? SACC_NEG_VREF : SACC_NEG_GND, 5'(i * 2 + 17),
                i[2] ? (i[1] ? 10'h3ff : 10'h155) : (i[1] ? 10'h000 : 10'h3ff));
        wr(SACC_REG_CFG, 8'h58);
        t_trig(3'h1, 8'h00, 0, 1);
        t_trig(3'h3, 8'h00, 1, 0);
        t_trig(3'h2, 8'h00, 2, 3);
        t_trig(3'h2, 8'h02, 3, 2);
        t_trig(3'h5, 8'h00, 4, 5);
        t_trig(3'h5, 8'h04, 5, 4);
        t_trig(3'h4, 8'h00, 6, 0);
        t_trig(3'h6, 8'h00, 7, 0);
        t_pin_lp;
        finish_test;
    end
endmodule : tb_sacc_ctrl
`default_nettype wire
